/* File: instr_cycle_decoder.sv */
/*
 * Instruction format and cycle decoder: four-phase instruction cycle
 * sequencer, operand field split, two-word handling and cycle counting.
 * Assumes program memory presents the next sequential word by the end of
 * each cycle's last phase, and the datapath reports condition results and
 * program counter writes in that same phase, on the same clock.
 */
`timescale 1ns/1ps

module instr_cycle_decoder
    import idec_pkg::*;
(
    input  wire logic                        i_mclk,           // oscillator clock
    input  wire logic                        i_nrst,           // async reset, active low
    input  wire logic [idec_pkg::WORD_W-1:0] i_fetch_word,     // next program word
    input  wire logic                        i_cond_true,      // skip/branch test result
    input  wire logic                        i_pc_written,     // datapath wrote the pc
    input  wire logic                        i_ext_enable,     // extended set enabled
    output logic [1:0]                       o_phase,          // phase in cycle
    output logic                             o_cycle_start,    // first phase pulse
    output logic                             o_fetch_strobe,   // word taken this phase
    output idec_pkg::format_t                o_format,         // instruction class
    output logic [idec_pkg::WORD_W-1:0]      o_instr,          // executing first word
    output logic [7:0]                       o_file_addr,      // file register address
    output logic                             o_to_file,        // result to file register
    output logic                             o_use_bank,       // bank register selects bank
    output logic [2:0]                       o_bit_num,        // affected bit
    output logic [7:0]                       o_literal,        // literal value
    output logic [1:0]                       o_fsp_sel,        // file_select_pointer number
    output logic [idec_pkg::OFFS_W-1:0]      o_rel_offset,     // signed branch offset
    output logic [idec_pkg::LONG_W-1:0]      o_long_addr,      // two-word operand
    output logic                             o_fast,           // shadow registers used
    output logic                             o_tbl_op,         // table read/write
    output logic                             o_tbl_write,      // table write
    output logic [1:0]                       o_tbl_mode,       // table_pointer mode
    output logic                             o_two_word,       // two-word instruction
    output logic                             o_second,         // second word cycle
    output logic                             o_conditional,    // has a test
    output logic                             o_pc_change,      // changes the pc
    output logic                             o_extended,       // extended-set instruction
    output logic                             o_nop,            // cycle executes as no-op
    output logic                             o_flush,          // discarded fetch cycle
    output logic                             o_retire,         // previous instr done
    output logic [1:0]                       o_retire_cycles   // its cycle count
);
    import idec_pkg::*;

    // ************************************************************
    // sequencing decisions at the last phase
    // ************************************************************
    logic              boundary;
    logic              cont;
    logic              flush_nxt;
    logic              skip_tail;
    logic              new_instr;
    logic              raw_two;
    logic              flushed_two_r;
    logic [1:0]        cnt_r;
    logic [15:0]       lw;

    assign boundary  = (o_phase == PHASE_LAST);
    // first word of a two-word instruction pulls in its second word
    assign cont      = o_two_word & ~o_second & ~o_nop;
    assign flush_nxt = ~o_nop & ~o_two_word
                     & (o_pc_change | (o_conditional & i_cond_true) | i_pc_written);
    // a skipped two-word instruction loses both words, hence three cycles
    assign skip_tail = o_flush & flushed_two_r;
    assign new_instr = ~cont & ~flush_nxt & ~skip_tail;
    assign lw        = (flush_nxt | skip_tail) ? NOP_WORD : i_fetch_word;

    // ************************************************************
    // field decode of the word being loaded
    // ************************************************************
    logic [3:0] hi4;
    logic       is_second;
    logic       is_bit;
    logic       is_ctl0;
    logic       is_lit;
    logic       is_byte;
    logic       is_rel;
    logic       is_cbr;
    logic       is_call;
    logic       is_goto;
    logic       is_lfsp;
    logic       is_movff;
    logic       is_ret;
    logic       is_tbl;
    logic       is_ext_hi;
    logic       is_callw;
    logic       ext_ok;
    logic       ext_off;
    logic       d_two;
    logic       d_cond;
    logic       d_pcc;
    logic       d_nop;
    format_t    d_fmt;

    assign hi4       = lw[15:12];
    assign is_second = (hi4 == HI_SECOND);
    assign is_bit    = (lw[15:14] == TOP2_BIT) | (hi4 == HI_BTG);
    assign is_ctl0   = (lw[15:8] == TOP8_CTRL);
    assign is_movff  = (hi4 == HI_MOVE_FF);
    assign is_rel    = (hi4 == HI_REL_JUMP);
    assign is_cbr    = (lw[15:11] == TOP5_COND_BR);
    assign is_call   = (lw[15:9] == TOP7_CALL);
    assign is_goto   = (lw[15:8] == TOP8_GOTO);
    assign is_lfsp   = (lw[15:8] == TOP8_LOAD_FSP);
    assign is_ext_hi = (lw[15:10] == TOP6_EXT);
    assign is_callw  = is_ctl0 & (lw[7:0] == LO8_CALL_W);
    assign ext_ok    = (is_ext_hi | is_callw) & i_ext_enable;
    // extended opcodes with the set disabled execute as no-ops
    assign ext_off   = (is_ext_hi | is_callw) & ~i_ext_enable;
    assign is_tbl    = is_ctl0 & (lw[7:3] == LO5_TABLE);
    assign is_ret    = is_ctl0 & (lw[7:2] == LO6_RETURN);
    assign is_lit    = (lw[15:11] == TOP5_LIT) | (lw[15:8] == TOP8_BANK_LIT)
                     | is_lfsp | (is_ext_hi & ext_ok);
    assign is_byte   = ((hi4 <= HI_BYTE_MAX) & ~is_ctl0 & ~is_lit) | is_movff;
    assign d_two     = is_movff | is_call | is_lfsp | is_goto;
    assign d_cond    = (lw[15:10] == TOP6_DEC_SZ) | (lw[15:10] == TOP6_INC_SZ)
                     | (lw[15:10] == TOP6_INC_SNZ) | (lw[15:10] == TOP6_DEC_SNZ)
                     | (lw[15:11] == TOP5_CMP_SKIP) | (hi4 == HI_SKIP_SET)
                     | (hi4 == HI_SKIP_CLR) | is_cbr;
    assign d_pcc     = is_rel | is_goto | is_call | is_ret | (lw[15:8] == TOP8_RET_LIT)
                     | (is_ctl0 & (lw[7:0] == LO8_RESET)) | (is_callw & ext_ok);
    assign d_nop     = is_second | ext_off | (lw == NOP_WORD);
    assign d_fmt     = (is_second | ext_off) ? FMT_NOP  :
                       is_bit                ? FMT_BIT  :
                       is_lit                ? FMT_LIT  :
                       is_byte               ? FMT_BYTE : FMT_CTRL;

    // raw fetched word decides whether a skipped instruction had two words
    assign raw_two   = (i_fetch_word[15:12] == HI_MOVE_FF)
                     | (i_fetch_word[15:9] == TOP7_CALL)
                     | (i_fetch_word[15:8] == TOP8_LOAD_FSP)
                     | (i_fetch_word[15:8] == TOP8_GOTO);

    // ************************************************************
    // phase sequencer
    // ************************************************************
    always_ff @(posedge i_mclk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            o_phase        <= 2'h0;
            o_cycle_start  <= 1'b0;
            o_fetch_strobe <= 1'b0;
        end
        else
        begin
            o_phase        <= o_phase + 2'h1;
            o_cycle_start  <= boundary;
            o_fetch_strobe <= (o_phase == PHASE_PRE);
        end
    end

    // ************************************************************
    // decoded operand registers, loaded at each last phase unless the second word is pulled in
    // ************************************************************
    always_ff @(posedge i_mclk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            o_format      <= FMT_CTRL;
            o_instr       <= NOP_WORD;
            o_file_addr   <= 8'h00;
            o_to_file     <= 1'b0;
            o_use_bank    <= 1'b0;
            o_bit_num     <= 3'h0;
            o_literal     <= 8'h00;
            o_fsp_sel     <= 2'h0;
            o_rel_offset  <= 11'h000;
            o_fast        <= 1'b0;
            o_tbl_op      <= 1'b0;
            o_tbl_write   <= 1'b0;
            o_tbl_mode    <= TBL_KEEP;
            o_two_word    <= 1'b0;
            o_conditional <= 1'b0;
            o_pc_change   <= 1'b0;
            o_extended    <= 1'b0;
        end
        else if (boundary && !cont)
        begin
            o_format      <= d_fmt;
            o_instr       <= lw;
            o_file_addr   <= lw[7:0];
            o_to_file     <= lw[9];
            o_use_bank    <= lw[8];
            o_bit_num     <= lw[11:9];
            o_literal     <= lw[7:0];
            o_fsp_sel     <= lw[5:4];
            o_rel_offset  <= is_rel ? lw[10:0] : {{3{lw[7]}}, lw[7:0]};
            o_fast        <= is_call ? lw[8] : (is_ret & lw[0]);
            o_tbl_op      <= is_tbl;
            o_tbl_write   <= is_tbl & lw[2];
            o_tbl_mode    <= is_tbl ? lw[1:0] : TBL_KEEP;
            o_two_word    <= d_two;
            o_conditional <= d_cond;
            o_pc_change   <= d_pcc;
            o_extended    <= ext_ok;
        end
    end

    // ************************************************************
    // cycle flags, second word and retirement count
    // ************************************************************
    always_ff @(posedge i_mclk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            o_nop         <= 1'b1;
            o_flush       <= 1'b0;
            o_second      <= 1'b0;
            flushed_two_r <= 1'b0;
            o_long_addr   <= 20'h00000;
            cnt_r         <= CYC_ONE;
            o_retire      <= 1'b0;
        end
        else if (boundary)
        begin
            o_nop         <= ~cont & d_nop;
            o_flush       <= flush_nxt | skip_tail;
            o_second      <= cont;
            flushed_two_r <= flush_nxt & raw_two;
            cnt_r         <= new_instr ? CYC_ONE : cnt_r + 2'h1;
            o_retire      <= new_instr;
            if (cont)
            begin
                o_long_addr <= {i_fetch_word[11:0], o_file_addr};
            end
        end
        else
        begin
            o_retire <= 1'b0;
        end
    end

    always_ff @(posedge i_mclk or negedge i_nrst)
    begin
        if (!i_nrst)
            o_retire_cycles <= 2'h0;
        else if (boundary && new_instr)
            o_retire_cycles <= cnt_r;
    end

endmodule

/* File: idec_pkg.sv */
/*
 * Constants shared by the instruction format and cycle decoder: phase
 * counts, opcode pattern values and operand field layouts.
 * Assumes 16-bit program words fetched from on-chip program memory.
 */
package idec_pkg;

    // ************************************************************
    // widths and sequencing
    // ************************************************************
    localparam int          WORD_W        = 16;
    localparam int          LONG_W        = 20;
    localparam int          OFFS_W        = 11;
    localparam int          PHASES        = 4;
    localparam logic [1:0]  PHASE_LAST    = 2'h3;
    localparam logic [1:0]  PHASE_PRE     = 2'h2;
    localparam logic [1:0]  CYC_ONE       = 2'h1;
    localparam logic [15:0] NOP_WORD      = 16'h0000;

    // ************************************************************
    // opcode patterns
    // ************************************************************
    localparam logic [3:0]  HI_SECOND     = 4'hf;
    localparam logic [3:0]  HI_BTG        = 4'h7;
    localparam logic [3:0]  HI_BYTE_MAX   = 4'h6;
    localparam logic [3:0]  HI_SKIP_SET   = 4'ha;
    localparam logic [3:0]  HI_SKIP_CLR   = 4'hb;
    localparam logic [3:0]  HI_MOVE_FF    = 4'hc;
    localparam logic [3:0]  HI_REL_JUMP   = 4'hd;
    localparam logic [1:0]  TOP2_BIT      = 2'h2;
    localparam logic [4:0]  TOP5_COND_BR  = 5'h1c;
    localparam logic [4:0]  TOP5_LIT      = 5'h01;
    localparam logic [4:0]  TOP5_CMP_SKIP = 5'h0c;
    localparam logic [5:0]  TOP6_EXT      = 6'h3a;
    localparam logic [5:0]  TOP6_DEC_SZ   = 6'h0b;
    localparam logic [5:0]  TOP6_INC_SZ   = 6'h0f;
    localparam logic [5:0]  TOP6_INC_SNZ  = 6'h12;
    localparam logic [5:0]  TOP6_DEC_SNZ  = 6'h13;
    localparam logic [6:0]  TOP7_CALL     = 7'h76;
    localparam logic [7:0]  TOP8_CTRL     = 8'h00;
    localparam logic [7:0]  TOP8_BANK_LIT = 8'h01;
    localparam logic [7:0]  TOP8_RET_LIT  = 8'h0c;
    localparam logic [7:0]  TOP8_LOAD_FSP = 8'hee;
    localparam logic [7:0]  TOP8_GOTO     = 8'hef;
    localparam logic [4:0]  LO5_TABLE     = 5'h01;
    localparam logic [5:0]  LO6_RETURN    = 6'h04;
    localparam logic [7:0]  LO8_CALL_W    = 8'h14;
    localparam logic [7:0]  LO8_RESET     = 8'hff;

    // ************************************************************
    // table pointer modes
    // ************************************************************
    localparam logic [1:0]  TBL_KEEP      = 2'h0;
    localparam logic [1:0]  TBL_POST_INC  = 2'h1;
    localparam logic [1:0]  TBL_POST_DEC  = 2'h2;
    localparam logic [1:0]  TBL_PRE_INC   = 2'h3;

    typedef enum logic [2:0] {
        FMT_NOP  = 3'b000,
        FMT_BYTE = 3'b001,
        FMT_BIT  = 3'b010,
        FMT_LIT  = 3'b011,
        FMT_CTRL = 3'b100
    } format_t;

endpackage

/* File: prog_mem_model.sv */
/*
 * Program memory and datapath stand-in: one word per fetch strobe, plus
 * the test result and pc write report of the word fetched before it.
 * Assumes the decoder samples these at the edge that ends its strobe.
 */
`timescale 1ns/1ps

module prog_mem_model
(
    input  wire logic        i_mclk,   // oscillator clock
    input  wire logic        i_nrst,   // async reset, active low
    input  wire logic        i_strobe, // fetch strobe from decoder
    output logic [15:0]      o_word,   // program word
    output logic             o_cond,   // test result of prior word
    output logic             o_pcw     // prior word wrote the pc
);
    logic [15:0] prog [32];
    logic        cond [32];
    logic        pcw  [32];
    int          idx = 0;
    logic        take;

    // off the strobe the lines carry the inverse, so stale data never matches
    always @(posedge i_mclk or negedge i_nrst)
    begin
        take = i_strobe;
        #1;
        if (!i_nrst)
            idx = 0;
        else if (take)
            idx = idx + 1;
        o_word = i_strobe ? prog[idx] : ~prog[idx];
        o_cond = (idx > 0) ? cond[idx-1] ^ !i_strobe : 1'b1;
        o_pcw  = (idx > 0) ? pcw[idx-1] ^ !i_strobe : 1'b1;
    end
endmodule

/* File: instr_cycle_decoder_assertions.sv */
/*
 * Port-level checker for the instruction decoder, bound into it.
 * Assumes one clock domain and the package's format codes.
 */
`timescale 1ns/1ps

module instr_cycle_decoder_checker
    import idec_pkg::*;
(
    input  wire logic                  i_mclk,          // clock
    input  wire logic                  i_nrst,          // reset, active low
    input  wire logic                  o_cycle_start,   // first phase
    input  wire logic                  o_fetch_strobe,  // fetch phase
    input  wire idec_pkg::format_t     o_format,        // class
    input  wire logic [15:0]           o_instr,         // first word
    input  wire logic [7:0]            o_file_addr,     // file address
    input  wire logic                  o_to_file,       // destination
    input  wire logic                  o_use_bank,      // access selector
    input  wire logic [2:0]            o_bit_num,       // bit number
    input  wire logic                  o_tbl_op,        // table op
    input  wire logic                  o_tbl_write,     // table write
    input  wire logic [1:0]            o_tbl_mode,      // pointer mode
    input  wire logic                  o_two_word,      // two words
    input  wire logic                  o_second,        // second word
    input  wire logic                  o_nop,           // no-op cycle
    input  wire logic                  o_flush,         // discarded
    input  wire logic                  o_retire,        // retire pulse
    input  wire logic [1:0]            o_retire_cycles  // cycle count
);
    default clocking @(posedge i_mclk); endclocking
    default disable iff (!i_nrst);

    sequence second_cyc;
        ##4 (o_cycle_start && o_second);
    endsequence
    sequence retire_two;
        ##4 (o_retire && o_retire_cycles == 2'h2);
    endsequence

    cycle_len_a: assert property ($rose(o_cycle_start) |=> !o_cycle_start [*3] ##1 o_cycle_start)
        else $error("cycle start not every four clocks");
    fetch_phase_a: assert property (o_cycle_start |-> ##3 (o_fetch_strobe && !o_cycle_start))
        else $error("fetch strobe not in last phase");
    fields_hold_a: assert property (o_cycle_start |=> ($stable(o_instr) && $stable(o_format)) [*3])
        else $error("decoded word changed inside a cycle");
    byte_fields_a: assert property (
        o_format == FMT_BYTE |-> o_file_addr == o_instr[7:0]
        && o_to_file == o_instr[9] && o_use_bank == o_instr[8])
        else $error("byte operand fields wrong");
    bit_fields_a: assert property (o_format == FMT_BIT
        |-> o_bit_num == o_instr[11:9]
        && o_file_addr == o_instr[7:0] && o_use_bank == o_instr[8])
        else $error("bit operand fields wrong");
    two_word_a: assert property (o_cycle_start && o_two_word && !o_second
        |-> second_cyc ##0 retire_two)
        else $error("two-word timing wrong");
    lone_second_a: assert property (o_cycle_start && !o_second
        && o_instr[15:12] == HI_SECOND |-> o_nop && o_format == FMT_NOP)
        else $error("lone second word not a no-op");
    flush_nop_a: assert property (o_flush |-> o_nop && o_instr == NOP_WORD)
        else $error("flushed cycle not a no-op");
    table_mode_a: assert property (
        o_tbl_mode == (o_tbl_op ? o_instr[1:0] : TBL_KEEP)
        && (!o_tbl_op || o_tbl_write == o_instr[2]))
        else $error("table mode field wrong");
    retire_start_a: assert property (o_retire |-> o_cycle_start && $past(o_fetch_strobe))
        else $error("retire outside cycle start");
endmodule

bind instr_cycle_decoder instr_cycle_decoder_checker chk (.*);

/* File: tb_top.sv */
/*
 * Self-checking bench for the instruction decoder with a program memory
 * stand-in. Assumes 100 ns clock; inputs change 1 ns after rising edges.
 */
`timescale 1ns/1ps

module tb_top;
    import idec_pkg::*;
    logic        i_mclk = 1'b0;
    logic        i_nrst, i_cond_true, i_pc_written, i_ext_enable;
    logic [15:0] i_fetch_word, o_instr;
    logic        o_cycle_start, o_fetch_strobe, o_to_file, o_use_bank, o_fast, o_tbl_op;
    logic        o_tbl_write, o_two_word, o_second, o_conditional, o_pc_change;
    logic        o_extended, o_nop, o_flush, o_retire;
    logic [1:0]  o_phase, o_fsp_sel, o_tbl_mode, o_retire_cycles;
    logic [2:0]  o_bit_num;
    logic [7:0]  o_file_addr, o_literal;
    logic [10:0] o_rel_offset;
    logic [19:0] o_long_addr;
    format_t     o_format;
    int          fails = 0;
    int          compares = 0;

    instr_cycle_decoder uut (.*);
    prog_mem_model pm (.i_mclk, .i_nrst, .i_strobe(o_fetch_strobe), .o_word(i_fetch_word),
        .o_cond(i_cond_true), .o_pcw(i_pc_written));

    always #50 i_mclk = ~i_mclk;

    // ****************************************
    // helpers
    // ****************************************
    task automatic chk(input string what, input logic [19:0] seen, input logic [19:0] exp);
        compares++;
        if (seen !== exp)
        begin
            fails++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic put(input int i, input logic [15:0] w, input logic c = 0, input logic p = 0);
        pm.prog[i] = w;
        pm.cond[i] = c;
        pm.pcw[i] = p;
    endtask

    task automatic hold;
        @(posedge i_mclk);
        #1;
        i_nrst = 1'b0;
        for (int i = 0; i < 32; i++)
            put(i, NOP_WORD);
    endtask

    task automatic go;
        repeat (2) @(posedge i_mclk);
        #1;
        i_nrst = 1'b1;
    endtask

    // bounded wait for the next instruction cycle, sampled once settled
    task automatic cyc;
        for (int n = 0; n < 8; n++)
        begin
            @(posedge i_mclk);
            #2;
            if (o_cycle_start === 1'b1)
                return;
        end
        chk("cycle start", 1'b0, 1'b1);
    endtask

    task automatic end_of_test;
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // ****************************************
    // scenarios
    // ****************************************
    task automatic t_fields;
        hold;
        put(0, 16'h2b34, 1'b1);
        put(1, 16'h2434);
        put(2, 16'h8d21);
        put(3, 16'h0e55, 1'b0, 1'b1);
        put(4, 16'h2434);
        go;
        cyc;
        chk("phase", o_phase, 2'h0);
        chk("retire", o_retire, 1'b1);
        chk("instr", o_instr, 16'h2b34);
        chk("format", o_format, FMT_BYTE);
        chk("file addr", o_file_addr, 8'h34);
        chk("to file", o_to_file, 1'b1);
        chk("use bank", o_use_bank, 1'b1);
        cyc;
        chk("to file", o_to_file, 1'b0);
        chk("flush", o_flush, 1'b0);
        chk("use bank", o_use_bank, 1'b0);
        cyc;
        chk("format", o_format, FMT_BIT);
        chk("bit num", o_bit_num, 3'h6);
        cyc;
        chk("format", o_format, FMT_LIT);
        chk("literal", o_literal, 8'h55);
        cyc;
        chk("flush", o_flush, 1'b1);
        cyc;
        chk("retire cycles", o_retire_cycles, 2'h2);
    endtask

    // pc write on the jump must not flush its second word
    task automatic t_two_word;
        hold;
        put(0, 16'hef12, 1'b0, 1'b1);
        put(1, 16'hf345);
        put(2, 16'hee20);
        put(3, 16'hf0ab);
        put(4, 16'hf123);
        put(5, 16'hed34);
        put(6, 16'hf000);
        put(7, 16'hec34);
        put(8, 16'hf000);
        go;
        cyc;
        chk("two word", o_two_word, 1'b1);
        chk("pc change", o_pc_change, 1'b1);
        cyc;
        chk("second", o_second, 1'b1);
        chk("flush", o_flush, 1'b0);
        chk("long addr", o_long_addr, 20'h34512);
        cyc;
        chk("retire cycles", o_retire_cycles, 2'h2);
        chk("fsp sel", o_fsp_sel, 2'h2);
        cyc;
        chk("long addr", o_long_addr, 20'h0ab20);
        cyc;
        chk("nop", o_nop, 1'b1);
        chk("format", o_format, FMT_NOP);
        cyc;
        chk("fast", o_fast, 1'b1);
        cyc;
        cyc;
        chk("fast", o_fast, 1'b0);
    endtask

    task automatic t_skip;
        hold;
        put(0, 16'hd005, 1'b0, 1'b1);
        put(1, 16'h2434);
        put(2, 16'h2c10, 1'b1);
        put(3, 16'h2434);
        put(4, 16'h2c10, 1'b1);
        put(5, 16'hef12);
        put(6, 16'hf345);
        put(7, 16'h2c10, 1'b0);
        put(8, 16'h2434);
        go;
        cyc;
        chk("rel offset", o_rel_offset, 11'h005);
        cyc;
        chk("flush", o_flush, 1'b1);
        chk("nop", o_nop, 1'b1);
        cyc;
        chk("retire cycles", o_retire_cycles, 2'h2);
        chk("conditional", o_conditional, 1'b1);
        cyc;
        chk("flush", o_flush, 1'b1);
        cyc;
        cyc;
        cyc;
        chk("flush", o_flush, 1'b1);
        cyc;
        chk("retire cycles", o_retire_cycles, 2'h3);
        cyc;
        chk("flush", o_flush, 1'b0);
        chk("retire cycles", o_retire_cycles, 2'h1);
    endtask

    task automatic t_ext_table;
        hold;
        i_ext_enable = 1'b0;
        for (int i = 0; i < 8; i++)
            put(i, 16'h0008 + 16'(i));
        put(8, 16'he800);
        go;
        for (int i = 0; i < 8; i++)
        begin
            cyc;
            chk("tbl op", o_tbl_op, 1'b1);
            chk("tbl write", o_tbl_write, i[2]);
            chk("tbl mode", o_tbl_mode, i[1:0]);
        end
        cyc;
        chk("nop", o_nop, 1'b1);
        hold;
        i_ext_enable = 1'b1;
        put(0, 16'he800);
        go;
        cyc;
        chk("extended", o_extended, 1'b1);
        chk("nop", o_nop, 1'b0);
    endtask

    initial
    begin
        i_nrst = 1'b0;
        i_ext_enable = 1'b0;
        repeat (8) @(posedge i_mclk);
        t_fields;
        t_two_word;
        t_skip;
        t_ext_table;
        end_of_test;
    end

    initial
    begin
        #300000;
        fails++;
        end_of_test;
    end
endmodule
